// ==== pkg/dew_pkg.sv ====
// Package of constants and types for the data EEPROM write controller.
// Assumes an 8-bit core data space and a 200 MHz core clock.
`default_nettype none
package dew_pkg;

   // ==========================================================
   // Data space addresses
   localparam logic [7:0] BANK_ADDR = 8'he8;
   localparam logic [7:0] CTL_ADDR = 8'hea;
   localparam logic [1:0] WIN_HI = 2'h0;

   // ==========================================================
   // Control register layout and reset value
   localparam int EN_BIT = 0;
   localparam int BUSY_BIT = 1;
   localparam int PE_BIT = 2;
   localparam int PS_BIT = 3;
   localparam int SB_BIT = 6;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] BANK_RESET = 8'h00;

   // ==========================================================
   // Bank select codes on bits {7,1,0} for pages 0 to 5
   localparam logic [2:0] SEL_PG0 = 3'h1;
   localparam logic [2:0] SEL_PG1 = 3'h2;
   localparam logic [2:0] SEL_PG2 = 3'h3;
   localparam logic [2:0] SEL_PG3 = 3'h5;
   localparam logic [2:0] SEL_PG4 = 3'h6;
   localparam logic [2:0] SEL_PG5 = 3'h7;

   // ==========================================================
   // Array geometry
   localparam int EE_BYTES = 384;
   localparam int PAGE_BYTES = 64;
   localparam int ROW_BYTES = 8;
   localparam int ROWS = EE_BYTES / ROW_BYTES;

   // ==========================================================
   // Programming time
   localparam int PROG_TIME_NS = 5_000_000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 24;

   // ==========================================================
   // Controller states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_PROG = 2'b10
   } dew_state_t;

endpackage
`default_nettype wire

// ==== pkg/dew_mem_if.sv ====
// Interface between the controller and the EEPROM array.
// Assumes one clock; read is combinational, programming acts at the clock.
`timescale 1ns/100ps
`default_nettype none
interface dew_mem_if;
   logic [8:0] rd_addr;
   logic [7:0] rd_data;
   logic pg_go;
   logic [5:0] pg_row;
   logic [63:0] pg_data;
   logic [7:0] pg_mask;

   modport ctl (output rd_addr, output pg_go, output pg_row, output pg_data,
      output pg_mask, input rd_data);
   modport mem (input rd_addr, input pg_go, input pg_row, input pg_data,
      input pg_mask, output rd_data);
endinterface
`default_nettype wire

// ==== rtl/dew_array.sv ====
// EEPROM cell array of 384 bytes, split into eight byte banks of 48 rows.
// Assumes the controller only asserts pg_go once programming time is over.
`timescale 1ns/100ps
`default_nettype none
module dew_array (
   input wire logic clk,
   dew_mem_if.mem mif
);

   logic [7:0] rd_bank [0:dew_pkg::ROW_BYTES-1];

   // ==========================================================
   // One bank per byte of a row; all masked bytes program together
   for (genvar i = 0; i < dew_pkg::ROW_BYTES; i++) begin : g_bank
      logic [7:0] cell_r [0:dew_pkg::ROWS-1];

      // Program the selected row byte
      always_ff @(posedge clk) begin
         if (mif.pg_go && mif.pg_mask[i]) begin
            cell_r[mif.pg_row] <= mif.pg_data[i*8 +: 8];
         end
      end

      assign rd_bank[i] = cell_r[mif.rd_addr[8:3]];
   end

   // Byte select from the low address bits
   assign mif.rd_data = rd_bank[mif.rd_addr[2:0]];

endmodule
`default_nettype wire

// ==== rtl/dew_row_latch.sv ====
// Eight volatile row latches with a written mark per byte.
// Assumes clear and load may come together; the load then survives alone.
`timescale 1ns/100ps
`default_nettype none
module dew_row_latch (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic load,
   input wire logic [2:0] idx,
   input wire logic [7:0] din,
   output logic [63:0] dout,
   output logic [7:0] mask
);

   logic [7:0] data_r [0:7];
   logic [7:0] data_nxt [0:7];
   logic [7:0] mask_r;
   logic [7:0] mask_nxt;

   // ==========================================================
   // Per-byte latch and mark
   for (genvar i = 0; i < 8; i++) begin : g_lat
      // Next value of one latch
      always_comb begin
         data_nxt[i] = clear ? 8'h00 : data_r[i];
         mask_nxt[i] = clear ? 1'b0 : mask_r[i];
         if (load && (idx == 3'(i))) begin
            data_nxt[i] = din;
            mask_nxt[i] = 1'b1;
         end
      end

      // Latch storage
      always_ff @(posedge clk) begin
         if (rst) begin
            data_r[i] <= 8'h00;
            mask_r[i] <= 1'b0;
         end else begin
            data_r[i] <= data_nxt[i];
            mask_r[i] <= mask_nxt[i];
         end
      end

      assign dout[i*8 +: 8] = data_r[i];
   end

   assign mask = mask_r;

endmodule
`default_nettype wire

// ==== rtl/dew_ctrl.sv ====
// Data EEPROM write controller: paged window, control register, timed writes.
// Assumes the core bus is synchronous to clk with one-cycle read/write strobes.
`timescale 1ns/100ps
`default_nettype none
module dew_ctrl #(
   parameter int unsigned PROG_CYC = dew_pkg::PROG_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic cpu_rvalid,
   output logic cpu_rhit,
   output logic ee_busy,
   output logic ee_standby
);

   // Loaded one short: the terminal count cycle is busy as well
   localparam logic [dew_pkg::CNT_W-1:0] CNT_LOAD = dew_pkg::CNT_W'(PROG_CYC - 1);

   // Carrier to the cell array
   dew_mem_if mif ();

   // ==========================================================
   // State
   dew_pkg::dew_state_t state_r, state_nxt;
   logic [dew_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [7:0] bank_r, bank_nxt;
   logic en_r, en_nxt;
   logic pe_r, pe_nxt;
   logic ps_r, ps_nxt;
   logic sb_r, sb_nxt;
   logic row_lat_r, row_lat_nxt;
   logic [5:0] row_r, row_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic rhit_r, rhit_nxt;

   // ==========================================================
   // Decode
   logic [2:0] page;
   logic page_ok;
   logic [8:0] ee_addr;
   logic win_hit;
   logic ctl_hit;
   logic bank_hit;
   logic busy;
   logic lat_clr;
   logic lat_load;
   logic pg_go;
   logic [63:0] lat_data;
   logic [7:0] lat_mask;
   logic ctl_wr;
   logic win_wr;
   logic pe_set;
   logic pe_drop;
   logic ps_ok;
   logic row_same;

   // Page from bank select bits 7, 1 and 0
   always_comb begin
      page = 3'h0;
      page_ok = 1'b1;
      case ({bank_r[7], bank_r[1:0]})
         dew_pkg::SEL_PG0: page = 3'h0;
         dew_pkg::SEL_PG1: page = 3'h1;
         dew_pkg::SEL_PG2: page = 3'h2;
         dew_pkg::SEL_PG3: page = 3'h3;
         dew_pkg::SEL_PG4: page = 3'h4;
         dew_pkg::SEL_PG5: page = 3'h5;
         // Other codes leave the window unclaimed
         default: page_ok = 1'b0;
      endcase
   end

   // Window and register hits
   assign ee_addr = {page, cpu_addr[5:0]};
   assign win_hit = (cpu_addr[7:6] == dew_pkg::WIN_HI) && page_ok;
   assign ctl_hit = (cpu_addr == dew_pkg::CTL_ADDR);
   assign bank_hit = (cpu_addr == dew_pkg::BANK_ADDR);
   assign busy = (state_r == dew_pkg::ST_PROG);

   // Write qualifiers; busy gating is left to the sequencer state
   assign ctl_wr = cpu_wr && ctl_hit;
   assign win_wr = cpu_wr && win_hit && en_r && !sb_r;
   assign pe_set = cpu_wdata[dew_pkg::PE_BIT] && !pe_r;
   assign pe_drop = !cpu_wdata[dew_pkg::PE_BIT] && pe_r;
   assign ps_ok = cpu_wdata[dew_pkg::PS_BIT] && cpu_wdata[dew_pkg::PE_BIT] && en_r && pe_r;
   assign row_same = (ee_addr[8:3] == row_r);

   // ==========================================================
   // Submodules
   // Row latches; byte mode uses one of them too
   dew_row_latch dew_row_latch_inst (
      .clk(clk),
      .rst(rst),
      .clear(lat_clr),
      .load(lat_load),
      .idx(ee_addr[2:0]),
      .din(cpu_wdata),
      .dout(lat_data),
      .mask(lat_mask)
   );

   // Cell array, written only when a programming time ends
   dew_array dew_array_inst (
      .clk(clk),
      .mif(mif.mem)
   );

   // Array connections
   // Address parks at zero off-window and in standby to keep reads quiet
   assign mif.rd_addr = (win_hit && !sb_r) ? ee_addr : 9'h000;
   assign mif.pg_go = pg_go;
   assign mif.pg_row = row_r;
   assign mif.pg_data = lat_data;
   assign mif.pg_mask = lat_mask;

   // ==========================================================
   // Bank select register, write only and never gated by busy
   always_comb begin
      bank_nxt = bank_r;
      if (cpu_wr && bank_hit) begin
         bank_nxt = cpu_wdata;
      end
   end

   // Bank register storage
   always_ff @(posedge clk) begin
      if (rst) begin
         bank_r <= dew_pkg::BANK_RESET;
      end else begin
         bank_r <= bank_nxt;
      end
   end

   // ==========================================================
   // Control register and programming sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      en_nxt = en_r;
      pe_nxt = pe_r;
      ps_nxt = ps_r;
      sb_nxt = sb_r;
      row_lat_nxt = row_lat_r;
      row_nxt = row_r;
      lat_clr = 1'b0;
      lat_load = 1'b0;
      pg_go = 1'b0;
      case (state_r)
         dew_pkg::ST_IDLE: begin
            if (ctl_wr) begin
               // Test bits and D7 are not stored; standby does not block this
               en_nxt = cpu_wdata[dew_pkg::EN_BIT];
               sb_nxt = cpu_wdata[dew_pkg::SB_BIT];
               pe_nxt = cpu_wdata[dew_pkg::PE_BIT];
               if (pe_set) begin
                  lat_clr = 1'b1;
                  row_lat_nxt = 1'b0;
               end
               if (pe_drop) begin
                  lat_clr = 1'b1;
                  row_lat_nxt = 1'b0;
               end
               // Row start needs EN and PE already set and PE kept set here
               if (ps_ok) begin
                  ps_nxt = 1'b1;
                  state_nxt = dew_pkg::ST_PROG;
                  cnt_nxt = CNT_LOAD;
               end
            end else if (win_wr) begin
               if (pe_r) begin
                  if (!row_lat_r) begin
                     row_lat_nxt = 1'b1;
                     row_nxt = ee_addr[8:3];
                     lat_load = 1'b1;
                  end else if (row_same) begin
                     // Other rows are dropped so the latched row stays intact
                     lat_load = 1'b1;
                  end
               end else begin
                  // Byte mode: one latch holds the byte while it programs
                  lat_clr = 1'b1;
                  lat_load = 1'b1;
                  row_nxt = ee_addr[8:3];
                  state_nxt = dew_pkg::ST_PROG;
                  cnt_nxt = CNT_LOAD;
               end
            end
         end
         dew_pkg::ST_PROG: begin
            // Control and window writes are dropped until the time is up; bank writes and reads still go through
            if (cnt_r == '0) begin
               // Latches clear on this edge; the array takes their old contents
               pg_go = 1'b1;
               lat_clr = 1'b1;
               pe_nxt = 1'b0;
               ps_nxt = 1'b0;
               row_lat_nxt = 1'b0;
               state_nxt = dew_pkg::ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: begin
            state_nxt = dew_pkg::ST_IDLE;
         end
      endcase
   end

   // Registers of the control path; reset gives control 00h
   // Array cells are not reset; only control state clears
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= dew_pkg::ST_IDLE;
         cnt_r <= '0;
         en_r <= dew_pkg::CTL_RESET[dew_pkg::EN_BIT];
         pe_r <= dew_pkg::CTL_RESET[dew_pkg::PE_BIT];
         ps_r <= dew_pkg::CTL_RESET[dew_pkg::PS_BIT];
         sb_r <= dew_pkg::CTL_RESET[dew_pkg::SB_BIT];
         row_lat_r <= 1'b0;
         row_r <= 6'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         en_r <= en_nxt;
         pe_r <= pe_nxt;
         ps_r <= ps_nxt;
         sb_r <= sb_nxt;
         row_lat_r <= row_lat_nxt;
         row_r <= row_nxt;
      end
   end

   // ==========================================================
   // Read path, one cycle after the strobe for every claimed address
   always_comb begin
      rdata_nxt = 8'h00;
      rhit_nxt = 1'b0;
      rvalid_nxt = cpu_rd;
      if (cpu_rd && ctl_hit) begin
         rhit_nxt = 1'b1;
         // Only busy shows; write-only bits read as zero
         rdata_nxt[dew_pkg::BUSY_BIT] = busy;
      end else if (cpu_rd && win_hit) begin
         rhit_nxt = 1'b1;
         // Busy or standby gives zero, never stale cell data
         if (!busy && !sb_r) begin
            rdata_nxt = mif.rd_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
         rhit_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         rhit_r <= rhit_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign cpu_rdata = rdata_r;
   assign cpu_rvalid = rvalid_r;
   assign cpu_rhit = rhit_r;
   assign ee_busy = busy;
   assign ee_standby = sb_r;

endmodule
`default_nettype wire

// ==== verif/dew_core_bfm.sv ====
// Core model issuing one-cycle data bus reads and writes.
// Assumes dew_ctrl answers a read one cycle after the strobe edge.
`timescale 1ns/100ps
`default_nettype none
module dew_core_bfm (
   input wire logic clk,
   output logic [7:0] cpu_addr,
   output logic cpu_wr,
   output logic cpu_rd,
   output logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   input wire logic cpu_rhit
);
   // Idle bus: strobes low, address unclaimed
   initial begin
      cpu_addr = 8'hff;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      cpu_wdata = 8'h00;
   end
   // Write strobe for one cycle; data inverted once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      cpu_addr = a;
      cpu_wdata = (a == dew_pkg::CTL_ADDR) ? (d & 8'hcf) : d;
      cpu_wr = 1'b1;
      @(negedge clk);
      cpu_wr = 1'b0;
      cpu_wdata = ~cpu_wdata;
      cpu_addr = 8'hff;
   endtask
   // Read strobe for one cycle; answer taken in the next cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(negedge clk);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge clk);
      d = cpu_rdata;
      h = cpu_rhit;
      cpu_rd = 1'b0;
      cpu_addr = 8'hff;
   endtask
endmodule
`default_nettype wire

// ==== verif/dew_ctrl_checker.sv ====
// Port checker for the data EEPROM write controller.
// Assumes it is bound to dew_ctrl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module dew_ctrl_checker #(
   parameter int unsigned PROG_CYC = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   input wire logic cpu_rvalid,
   input wire logic cpu_rhit,
   input wire logic ee_busy,
   input wire logic ee_standby
);
   logic [23:0] cnt_r;
   logic [23:0] cnt_nxt;
   // Busy cycle counter
   always_comb begin
      cnt_nxt = ee_busy ? cnt_r + 24'h000001 : 24'h000000;
   end
   always_ff @(posedge clk) begin
      cnt_r <= rst ? 24'h000000 : cnt_nxt;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ==========================================
   // Properties
   property p_rd_ans; cpu_rd |=> cpu_rvalid; endproperty
   property p_no_ans; !cpu_rd |=> !cpu_rvalid && !cpu_rhit && cpu_rdata == 8'h00; endproperty
   property p_ctl_rd; cpu_rd && cpu_addr == dew_pkg::CTL_ADDR |=> cpu_rhit && (cpu_rdata & 8'hfd) == 8'h00; endproperty
   property p_busy_ctl; cpu_rd && ee_busy && cpu_addr == dew_pkg::CTL_ADDR |=> cpu_rdata == 8'h02; endproperty
   property p_busy_win; cpu_rd && ee_busy && cpu_addr[7:6] == 2'h0 |=> cpu_rdata == 8'h00; endproperty
   property p_stby_win; cpu_rd && ee_standby && cpu_addr[7:6] == 2'h0 |=> cpu_rdata == 8'h00; endproperty
   property p_unclaimed; cpu_rd && cpu_addr[7:6] != 2'h0 && cpu_addr != dew_pkg::CTL_ADDR
      |=> !cpu_rhit && cpu_rdata == 8'h00; endproperty
   property p_busy_cause; $rose(ee_busy) |-> $past(cpu_wr); endproperty
   property p_busy_len; $fell(ee_busy) |-> cnt_r == 24'(PROG_CYC); endproperty
   property p_busy_max; ee_busy |-> cnt_r < 24'(PROG_CYC); endproperty
   property p_no_start; cpu_wr && !ee_busy && cpu_addr == dew_pkg::CTL_ADDR && !cpu_wdata[2]
      |=> !ee_busy; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   a_no_ans: assert property (p_no_ans) else $error("answer without read");
   a_ctl_rd: assert property (p_ctl_rd) else $error("control read bad");
   a_busy_ctl: assert property (p_busy_ctl) else $error("busy control read bad");
   a_busy_win: assert property (p_busy_win) else $error("window read while busy");
   a_stby_win: assert property (p_stby_win) else $error("window read in standby");
   a_unclaimed: assert property (p_unclaimed) else $error("unclaimed address hit");
   a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   a_busy_max: assert property (p_busy_max) else $error("busy too long");
   a_no_start: assert property (p_no_start) else $error("programming started");
   c_prog_done: cover property ($fell(ee_busy));
   c_busy_rd: cover property (cpu_rd && ee_busy);
   c_stby_rd: cover property (cpu_rd && ee_standby);
endmodule
bind dew_ctrl dew_ctrl_checker #(.PROG_CYC(PROG_CYC)) chk_inst (.clk(clk), .rst(rst),
   .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
   .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_rhit(cpu_rhit),
   .ee_busy(ee_busy), .ee_standby(ee_standby));
`default_nettype wire

// ==== verif/dew_ctrl_tb.sv ====
// Self-checking bench for dew_ctrl against a byte-array model.
// Assumes dew_core_bfm drives the bus; checker bound separately.
`timescale 1ns/100ps
`default_nettype none
module dew_ctrl_tb;
   localparam logic [7:0] CTL = dew_pkg::CTL_ADDR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] cpu_addr;
   logic cpu_wr;
   logic cpu_rd;
   logic [7:0] cpu_wdata;
   logic [7:0] cpu_rdata;
   logic cpu_rvalid;
   logic cpu_rhit;
   logic ee_busy;
   logic ee_standby;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [7:0] rd_d;
   logic rd_h;
   int mdl[384];
   logic [31:0] seed = 32'h00013b33;
   logic [7:0] codes[6] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83};
   dew_ctrl #(.PROG_CYC(20)) dew_ctrl_inst (.clk(clk), .rst(rst), .cpu_addr(cpu_addr),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_rvalid(cpu_rvalid), .cpu_rhit(cpu_rhit), .ee_busy(ee_busy), .ee_standby(ee_standby));
   dew_core_bfm dew_core_bfm_inst (.clk(clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
      .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rhit(cpu_rhit));
   // Clock and hang limit
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ==========================================
   // Helpers
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input int exp);
      logic [7:0] d;
      logic h;
      dew_core_bfm_inst.rd(a, d, h);
      check({7'h00, h}, 8'h01);
      if (exp >= 0) check(d, exp[7:0]);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (ee_busy !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      check({7'h00, ee_busy}, 8'h00);
   endtask
   // Byte write with accesses tried while busy, then read back
   task automatic bw(input int pg, input int off, input logic [7:0] d);
      dew_core_bfm_inst.wr(8'(off), d);
      check({7'h00, ee_busy}, 8'h01);
      rdc(8'(off), 0);
      rdc(CTL, 2);
      dew_core_bfm_inst.wr(CTL, 8'h00);
      dew_core_bfm_inst.wr(8'(off), ~d);
      wait_idle();
      mdl[pg * 64 + off] = d;
      rdc(8'(off), d);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      for (int i = 0; i < 384; i++) mdl[i] = -1;
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      rdc(CTL, 0);
      dew_core_bfm_inst.rd(8'h05, rd_d, rd_h);
      check({7'h00, rd_h}, 8'h00);
      check(rd_d, 8'h00);
      dew_core_bfm_inst.rd(dew_pkg::BANK_ADDR, rd_d, rd_h);
      check({7'h00, rd_h}, 8'h00);
      dew_core_bfm_inst.wr(CTL, 8'h81);
      rdc(CTL, 0);
      for (int pg = 0; pg < 6; pg++) begin
         dew_core_bfm_inst.wr(dew_pkg::BANK_ADDR, codes[pg]);
         bw(pg, int'(rnd() & 8'h27), rnd());
      end
      // Row work in page 0, row of 18h-1Fh; reads avoided while row enable set
      dew_core_bfm_inst.wr(dew_pkg::BANK_ADDR, 8'h01);
      bw(0, 8'h19, 8'h5a);
      bw(0, 8'h20, 8'ha5);
      dew_core_bfm_inst.wr(CTL, 8'h05);
      foreach (codes[i]) if (i < 3) dew_core_bfm_inst.wr(8'h18 + 8'(i + (i + 1) / 2), codes[i]);
      dew_core_bfm_inst.wr(8'h20, 8'h33);
      check({7'h00, ee_busy}, 8'h00);
      dew_core_bfm_inst.wr(CTL, 8'h0d);
      check({7'h00, ee_busy}, 8'h01);
      wait_idle();
      mdl[8'h18] = 8'h01;
      mdl[8'h1a] = 8'h02;
      mdl[8'h1b] = 8'h03;
      foreach (codes[i]) if (i < 4) rdc(8'h18 + 8'(i), mdl[8'h18 + i]);
      rdc(8'h20, mdl[8'h20]);
      bw(0, 8'h1c, rnd());
      // Abandon, then re-arm and program one byte
      dew_core_bfm_inst.wr(CTL, 8'h05);
      dew_core_bfm_inst.wr(8'h19, 8'h77);
      dew_core_bfm_inst.wr(CTL, 8'h01);
      check({7'h00, ee_busy}, 8'h00);
      rdc(8'h19, mdl[8'h19]);
      dew_core_bfm_inst.wr(CTL, 8'h05);
      dew_core_bfm_inst.wr(8'h1d, 8'h66);
      dew_core_bfm_inst.wr(CTL, 8'h0d);
      wait_idle();
      mdl[8'h1d] = 8'h66;
      rdc(8'h19, mdl[8'h19]);
      rdc(8'h1d, mdl[8'h1d]);
      // Start without row enable, write enable off, standby
      dew_core_bfm_inst.wr(CTL, 8'h09);
      check({7'h00, ee_busy}, 8'h00);
      dew_core_bfm_inst.wr(CTL, 8'h00);
      dew_core_bfm_inst.wr(8'h19, 8'h11);
      check({7'h00, ee_busy}, 8'h00);
      rdc(8'h19, mdl[8'h19]);
      dew_core_bfm_inst.wr(CTL, 8'h41);
      check({7'h00, ee_standby}, 8'h01);
      dew_core_bfm_inst.wr(8'h19, 8'h22);
      rdc(8'h19, 0);
      dew_core_bfm_inst.wr(CTL, 8'h01);
      // Final sweep of every modelled byte
      for (int pg = 0; pg < 6; pg++) begin
         dew_core_bfm_inst.wr(dew_pkg::BANK_ADDR, codes[pg]);
         for (int o = 0; o < 64; o++) if (mdl[pg * 64 + o] >= 0) rdc(8'(o), mdl[pg * 64 + o]);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
